// ===== pkg/mpt_pkg.sv
package mpt_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_MATCH = 7;
   localparam int NUM_OUT = 6;
   localparam int NUM_CAP = 2;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_PRESCALE = 8'h08;
   localparam logic [7:0] OFS_PS_COUNT = 8'h0c;
   localparam logic [7:0] OFS_CNT_MODE = 8'h10;
   localparam logic [7:0] OFS_MATCH_CTRL = 8'h14;
   localparam logic [7:0] OFS_RELEASE = 8'h18;
   localparam logic [7:0] OFS_OUT_CTRL = 8'h1c;
   localparam logic [7:0] OFS_MATCH_BASE = 8'h20;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h44;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h48;

   // control register fields
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_RESET_BIT = 1;
   localparam int CTRL_PWM_BIT = 3;
   localparam int CTRL_W = 4;

   // count mode fields: bits 1:0 source edge, bit 2 capture input select
   localparam int CMODE_SEL_BIT = 2;
   localparam int CMODE_W = 3;
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_RISE = 2'h1;
   localparam logic [1:0] MODE_FALL = 2'h2;
   localparam logic [1:0] MODE_BOTH = 2'h3;

   // match action fields, three bits per match slot
   localparam int MCTL_INT_OFS = 0;
   localparam int MCTL_RESET_OFS = 1;
   localparam int MCTL_STOP_OFS = 2;
   localparam int MCTL_STRIDE = 3;

   // output control fields
   localparam int OUT_DBL_LSB = 0;
   localparam int OUT_EN_LSB = 8;
   localparam int OUT_CTRL_W = 14;

   // reset values
   localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [CMODE_W-1:0] CMODE_RST = 3'h0;
   localparam logic [OUT_CTRL_W-1:0] OUT_CTRL_RST = 14'h0000;
endpackage

// ===== design/mpt_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser with agreement filter and edge pulses
module mpt_sync #(
   parameter int W = 2
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] lvl_reg;
   logic [W-1:0] lvl_next;
   logic [W-1:0] agree;

   // s1 feeds only s2, never any logic
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end
      else
      begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts only once stages two and three agree
   assign agree = ~(s2_reg ^ s3_reg);
   assign lvl_next = (s3_reg & agree) | (lvl_reg & ~agree);

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lvl_reg <= '0;
         rise <= '0;
         fall <= '0;
      end
      else
      begin
         lvl_reg <= lvl_next;
         rise <= lvl_next & ~lvl_reg;
         fall <= ~lvl_next & lvl_reg;
      end
   end
endmodule // mpt_sync

// ===== design/mpt_pwm.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
// Function
// - seven match slots, six pwm outputs
// - match may continue, stop, reset, interrupt
// - count clock or selected capture edges
// - single-edge outputs rise each cycle start
// - double-edge rise and fall anywhere
// - any width, one shared period
// - pwm-mode match values need software release first
// - plain prescaled timer without pwm mode
// - slot zero resets count, sets period
// - double-edge uses two slots each
module mpt_pwm (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [31:0] rd_data,
   input wire logic [1:0] cap_in,
   output logic [5:0] pwm_out,
   output logic irq
);
   localparam int NM = mpt_pkg::NUM_MATCH;
   localparam int NO = mpt_pkg::NUM_OUT;
   logic [mpt_pkg::CTRL_W-1:0] ctrl_reg;
   logic [mpt_pkg::CTRL_W-1:0] ctrl_next;
   logic [31:0] prescale_reg;
   logic [31:0] ps_cnt_reg;
   logic [31:0] tc_reg;
   logic [mpt_pkg::CMODE_W-1:0] cmode_reg;
   logic [NM*mpt_pkg::MCTL_STRIDE-1:0] mctl_reg;
   logic [NM-1:0] release_reg;
   logic [mpt_pkg::OUT_CTRL_W-1:0] out_ctrl_reg;
   logic [31:0] shadow_reg [NM];
   logic [31:0] active_reg [NM];
   logic [NM-1:0] irq_status_reg;
   logic [NM-1:0] irq_en_reg;
   logic [NO-1:0] pwm_reg;
   logic irq_reg;
   logic [31:0] rd_data_reg;
   logic [31:0] rd_next;
   logic [mpt_pkg::NUM_CAP-1:0] cap_rise;
   logic [mpt_pkg::NUM_CAP-1:0] cap_fall;
   logic src_edge;
   logic tick;
   logic running;
   logic pwm_mode;
   logic cnt_tick;
   logic [NM-1:0] match_hit;
   logic [NM-1:0] int_bits;
   logic [NM-1:0] reset_bits;
   logic [NM-1:0] stop_bits;
   logic reset_any;
   logic stop_any;
   logic boundary;
   logic [7:0] match_ofs;
   logic match_sel;
   logic [2:0] match_idx;

   assign rd_data = rd_data_reg;
   assign pwm_out = pwm_reg;
   assign irq = irq_reg;

   // capture pins arrive from outside the clock domain
   mpt_sync #(.W(mpt_pkg::NUM_CAP)) u_cap_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(cap_in),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   // count source: clock in timer mode, else chosen capture edge
   always_comb
   begin
      case (cmode_reg[1:0])
         mpt_pkg::MODE_RISE: src_edge = cap_rise[cmode_reg[mpt_pkg::CMODE_SEL_BIT]];
         mpt_pkg::MODE_FALL: src_edge = cap_fall[cmode_reg[mpt_pkg::CMODE_SEL_BIT]];
         mpt_pkg::MODE_BOTH: src_edge = cap_rise[cmode_reg[mpt_pkg::CMODE_SEL_BIT]]
                                       | cap_fall[cmode_reg[mpt_pkg::CMODE_SEL_BIT]];
         default: src_edge = 1'b0;
      endcase
   end
   assign tick = (cmode_reg[1:0] == mpt_pkg::MODE_TIMER) | src_edge;
   assign running = ctrl_reg[mpt_pkg::CTRL_RUN_BIT] & ~ctrl_reg[mpt_pkg::CTRL_RESET_BIT];
   assign pwm_mode = ctrl_reg[mpt_pkg::CTRL_PWM_BIT];
   assign cnt_tick = running & tick & (ps_cnt_reg == prescale_reg);

   // per-slot compare and action decode
   genvar gi;
   generate
      for (gi = 0; gi < NM; gi++)
      begin : g_match
         assign match_hit[gi] = cnt_tick & (tc_reg == active_reg[gi]);
         assign int_bits[gi] = mctl_reg[gi*mpt_pkg::MCTL_STRIDE + mpt_pkg::MCTL_INT_OFS];
         assign reset_bits[gi] = mctl_reg[gi*mpt_pkg::MCTL_STRIDE + mpt_pkg::MCTL_RESET_OFS];
         assign stop_bits[gi] = mctl_reg[gi*mpt_pkg::MCTL_STRIDE + mpt_pkg::MCTL_STOP_OFS];
      end
   endgenerate

   // in pwm mode slot zero always closes the period
   assign boundary = match_hit[0] & pwm_mode;
   assign reset_any = |(match_hit & reset_bits) | boundary;
   assign stop_any = |(match_hit & stop_bits);

   // match window decode, one aligned word per slot
   assign match_ofs = addr - mpt_pkg::OFS_MATCH_BASE;
   assign match_sel = (match_ofs[1:0] == 2'h0) && (match_ofs[7:2] < 6'(NM));
   assign match_idx = match_ofs[4:2];

   // control: a stop match beats a same-cycle software write
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (wr_strobe && addr == mpt_pkg::OFS_CTRL)
         ctrl_next = wr_data[mpt_pkg::CTRL_W-1:0];
      if (stop_any)
         ctrl_next[mpt_pkg::CTRL_RUN_BIT] = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         ctrl_reg <= mpt_pkg::CTRL_RST;
      else
         ctrl_reg <= ctrl_next;
   end

   // static configuration registers
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prescale_reg <= mpt_pkg::WORD_RST;
         cmode_reg <= mpt_pkg::CMODE_RST;
         mctl_reg <= '0;
         out_ctrl_reg <= mpt_pkg::OUT_CTRL_RST;
         irq_en_reg <= '0;
      end
      else if (wr_strobe)
      begin
         if (addr == mpt_pkg::OFS_PRESCALE)
            prescale_reg <= wr_data;
         if (addr == mpt_pkg::OFS_CNT_MODE)
            cmode_reg <= wr_data[mpt_pkg::CMODE_W-1:0];
         if (addr == mpt_pkg::OFS_MATCH_CTRL)
            mctl_reg <= wr_data[NM*mpt_pkg::MCTL_STRIDE-1:0];
         if (addr == mpt_pkg::OFS_OUT_CTRL)
            out_ctrl_reg <= wr_data[mpt_pkg::OUT_CTRL_W-1:0];
         if (addr == mpt_pkg::OFS_IRQ_ENABLE)
            irq_en_reg <= wr_data[NM-1:0];
      end
   end

   // prescaler and main count; the 32-bit pair is the plain timer
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ps_cnt_reg <= mpt_pkg::WORD_RST;
         tc_reg <= mpt_pkg::WORD_RST;
      end
      else if (ctrl_reg[mpt_pkg::CTRL_RESET_BIT])
      begin
         ps_cnt_reg <= mpt_pkg::WORD_RST;
         tc_reg <= mpt_pkg::WORD_RST;
      end
      else if (wr_strobe && addr == mpt_pkg::OFS_COUNT)
      begin
         ps_cnt_reg <= mpt_pkg::WORD_RST;
         tc_reg <= wr_data;
      end
      else if (running && tick)
      begin
         if (cnt_tick)
         begin
            ps_cnt_reg <= mpt_pkg::WORD_RST;
            tc_reg <= reset_any ? mpt_pkg::WORD_RST : tc_reg + 32'h1;
         end
         else
            ps_cnt_reg <= ps_cnt_reg + 32'h1;
      end
   end

   // release flags emptied at the boundary; a same-cycle write keeps its late bit
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         release_reg <= '0;
      else if (wr_strobe && addr == mpt_pkg::OFS_RELEASE)
         release_reg <= (boundary ? '0 : release_reg) | wr_data[NM-1:0];
      else if (boundary)
         release_reg <= '0;
   end

   // shadow and active compare values per slot
   generate
      for (gi = 0; gi < NM; gi++)
      begin : g_slot
         always_ff @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               shadow_reg[gi] <= mpt_pkg::WORD_RST;
               active_reg[gi] <= mpt_pkg::WORD_RST;
            end
            else
            begin
               if (wr_strobe && match_sel && match_idx == 3'(gi))
                  shadow_reg[gi] <= wr_data;
               // timer mode writes through; pwm mode waits for release
               if (!pwm_mode && wr_strobe && match_sel && match_idx == 3'(gi))
                  active_reg[gi] <= wr_data;
               else if (boundary && release_reg[gi])
                  active_reg[gi] <= shadow_reg[gi];
            end
         end
      end
   endgenerate

   // outputs: set and clear edges per output, clear wins on a tie
   generate
      for (gi = 0; gi < NO; gi++)
      begin : g_out
         logic dbl;
         logic set_ev;
         logic clr_ev;
         // output one has no lower slot to pair with
         assign dbl = (gi > 0) && out_ctrl_reg[mpt_pkg::OUT_DBL_LSB + gi];
         assign set_ev = dbl ? match_hit[gi] : match_hit[0];
         assign clr_ev = match_hit[gi+1];
         always_ff @(posedge ref_clk or negedge resetn)
         begin
            if (!resetn)
               pwm_reg[gi] <= 1'b0;
            else if (!pwm_mode || !out_ctrl_reg[mpt_pkg::OUT_EN_LSB + gi])
               pwm_reg[gi] <= 1'b0;
            else if (clr_ev)
               pwm_reg[gi] <= 1'b0;
            else if (set_ev)
               pwm_reg[gi] <= 1'b1;
         end
      end
   endgenerate

   // sticky match status, set beats clear
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_status_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         if (wr_strobe && addr == mpt_pkg::OFS_IRQ_CLEAR)
            irq_status_reg <= (irq_status_reg & ~wr_data[NM-1:0]) | (match_hit & int_bits);
         else
            irq_status_reg <= irq_status_reg | (match_hit & int_bits);
         irq_reg <= |(irq_status_reg & irq_en_reg);
      end
   end

   // read mux, unmapped and write-only offsets read zero
   always_comb
   begin
      rd_next = 32'h0000_0000;
      case (addr)
         mpt_pkg::OFS_CTRL: rd_next = 32'(ctrl_reg);
         mpt_pkg::OFS_COUNT: rd_next = tc_reg;
         mpt_pkg::OFS_PRESCALE: rd_next = prescale_reg;
         mpt_pkg::OFS_PS_COUNT: rd_next = ps_cnt_reg;
         mpt_pkg::OFS_CNT_MODE: rd_next = 32'(cmode_reg);
         mpt_pkg::OFS_MATCH_CTRL: rd_next = 32'(mctl_reg);
         mpt_pkg::OFS_RELEASE: rd_next = 32'(release_reg);
         mpt_pkg::OFS_OUT_CTRL: rd_next = 32'(out_ctrl_reg);
         mpt_pkg::OFS_IRQ_STATUS: rd_next = 32'(irq_status_reg);
         mpt_pkg::OFS_IRQ_ENABLE: rd_next = 32'(irq_en_reg);
         default: rd_next = match_sel ? shadow_reg[match_idx] : 32'h0000_0000;
      endcase
   end

   // data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         rd_data_reg <= 32'h0000_0000;
      else
         rd_data_reg <= rd_strobe ? rd_next : 32'h0000_0000;
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_boundary_rel1;
      boundary && release_reg[1];
   endsequence
   sequence s_slot1_loaded;
      active_reg[1] == $past(shadow_reg[1]);
   endsequence
   chk_period_reset: assert property (
      boundary && !ctrl_reg[mpt_pkg::CTRL_RESET_BIT]
      && !(wr_strobe && addr == mpt_pkg::OFS_COUNT) |=> tc_reg == 32'h0)
      else $error("period match did not clear count");
   chk_stop_action: assert property (
      stop_any |=> !ctrl_reg[mpt_pkg::CTRL_RUN_BIT])
      else $error("stop match left timer running");
   chk_irq_sticky: assert property (
      (match_hit & int_bits) != '0 |=> ##1
      (irq_status_reg & $past(match_hit & int_bits, 2)) == $past(match_hit & int_bits, 2)
      || $past(wr_strobe && addr == mpt_pkg::OFS_IRQ_CLEAR))
      else $error("match interrupt flag lost");
   chk_single_rise: assert property (
      pwm_mode && out_ctrl_reg[mpt_pkg::OUT_EN_LSB] && match_hit[0] && !match_hit[1]
      && !(wr_strobe && (addr == mpt_pkg::OFS_CTRL || addr == mpt_pkg::OFS_OUT_CTRL))
      |=> pwm_reg[0])
      else $error("single-edge output missed cycle start");
   chk_double_edges: assert property (
      pwm_mode && out_ctrl_reg[mpt_pkg::OUT_EN_LSB + 2] && out_ctrl_reg[mpt_pkg::OUT_DBL_LSB + 2]
      && match_hit[2] && !match_hit[3]
      && !(wr_strobe && (addr == mpt_pkg::OFS_CTRL || addr == mpt_pkg::OFS_OUT_CTRL))
      |=> pwm_reg[2])
      else $error("double-edge output missed its rise");
   chk_release_copy: assert property (
      s_boundary_rel1 |=> s_slot1_loaded)
      else $error("released value not loaded at boundary");
   chk_hold_unreleased: assert property (
      pwm_mode && !(boundary && release_reg[1]) |=> $stable(active_reg[1]))
      else $error("unreleased match value took effect");
   chk_prescale_step: assert property (
      running && tick && !cnt_tick && !wr_strobe |=>
      ps_cnt_reg == $past(ps_cnt_reg) + 32'h1 && $stable(tc_reg))
      else $error("prescaler step wrong");
   chk_edge_count: assert property (
      cmode_reg[1:0] != mpt_pkg::MODE_TIMER && !src_edge && !wr_strobe
      && !ctrl_reg[mpt_pkg::CTRL_RESET_BIT] |=> $stable(ps_cnt_reg) && $stable(tc_reg))
      else $error("counter moved without source edge");
endmodule // mpt_pwm

// ===== tb/mpt_load_model.sv
`timescale 1ns/1ps
// external loads: integrate high time and rising edges per output
module mpt_load_model (
   input wire logic ref_clk,
   input wire logic clr,
   input wire logic [5:0] pwm_out,
   output logic [15:0] hi_cnt [6],
   output logic [15:0] rise_cnt [6]
);
   logic [5:0] last_reg;

   // loads only sample the pins; they never load the driver back
   always_ff @(posedge ref_clk)
   begin
      last_reg <= pwm_out;
      for (int i = 0; i < 6; i++)
      begin
         hi_cnt[i] <= clr ? 16'h0 : hi_cnt[i] + 16'(pwm_out[i]);
         rise_cnt[i] <= clr ? 16'h0 : rise_cnt[i] + 16'(pwm_out[i] & ~last_reg[i]);
      end
   end
endmodule // mpt_load_model

// ===== tb/mpt_pwm_tb_top.sv
`timescale 1ns/1ps
module mpt_pwm_tb_top;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic clr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic [31:0] rd_data;
   logic [31:0] rv;
   logic [31:0] rv2;
   logic [1:0] cap_in = 2'h0;
   logic [5:0] pwm_out;
   logic irq;
   logic [15:0] hi_cnt [6];
   logic [15:0] rise_cnt [6];
   int err_count = 0;
   int checked = 0;
   int cycles = 0;

   // 125 MHz
   always #4 ref_clk = ~ref_clk;

   mpt_pwm u_dut (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .addr(addr),
      .wr_data(wr_data),
      .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe),
      .rd_data(rd_data),
      .cap_in(cap_in),
      .pwm_out(pwm_out),
      .irq(irq)
   );

   mpt_load_model u_load (
      .ref_clk(ref_clk),
      .clr(clr),
      .pwm_out(pwm_out),
      .hi_cnt(hi_cnt),
      .rise_cnt(rise_cnt)
   );

   task automatic print_verdict;
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // hang guard, well above the thousand or so cycles needed
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         $display("FAIL %0t timeout", $time);
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // x-safe range compare for counts read while the timer runs
   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checked++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
      begin
         err_count++;
         $display("FAIL %0t got %h range %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge ref_clk);
      wr_strobe <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge ref_clk);
      rd_strobe <= 1'b0;
      #1 d = rd_data;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      rd(a, rv);
      chk(rv, exp);
   endtask

   // ten periods of ten counts: totals independent of phase
   task automatic measure;
      @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (100) @(posedge ref_clk);
      #1;
   endtask

   task automatic test_regs;
      chk({30'h0, irq, pwm_out[0]}, 32'h0);
      rd_chk(mpt_pkg::OFS_CTRL, 32'h0);
      rd_chk(mpt_pkg::OFS_MATCH_BASE + 8'h04, 32'h0);
      wr(8'hfc, 32'hffff_ffff);
      rd_chk(8'hfc, 32'h0);
      wr(mpt_pkg::OFS_PRESCALE, 32'h3);
      rd_chk(mpt_pkg::OFS_PRESCALE, 32'h3);
      rd_chk(mpt_pkg::OFS_IRQ_CLEAR, 32'h0);
   endtask

   task automatic test_pwm;
      logic [31:0] mv [7] = '{9, 3, 0, 5, 7, 2, 4};
      logic [15:0] hexp [6] = '{40, 10, 50, 0, 50, 0};
      logic [15:0] rexp [6] = '{10, 10, 10, 0, 10, 0};
      wr(mpt_pkg::OFS_PRESCALE, 32'h0);
      for (int i = 0; i < 7; i++)
         wr(mpt_pkg::OFS_MATCH_BASE + 8'(4 * i), mv[i]);
      // outputs 3 and 5 double edge, 4 and 6 left disabled
      wr(mpt_pkg::OFS_OUT_CTRL, 32'h0000_1714);
      wr(mpt_pkg::OFS_CTRL, 32'h9);
      repeat (20) @(posedge ref_clk); // first period sets the outputs
      measure();
      for (int i = 0; i < 6; i++)
      begin
         chk({16'h0, hi_cnt[i]}, {16'h0, hexp[i]});
         chk({16'h0, rise_cnt[i]}, {16'h0, rexp[i]});
      end
      wr(mpt_pkg::OFS_MATCH_BASE + 8'h04, 32'h6);
      measure();
      chk({16'h0, hi_cnt[0]}, 32'd40);
      wr(mpt_pkg::OFS_RELEASE, 32'h2);
      repeat (25) @(posedge ref_clk);
      measure();
      chk({16'h0, hi_cnt[0]}, 32'd70);
      chk({16'h0, hi_cnt[2]}, 32'd50);
      // slot two equal to the period value holds output 2 low
      wr(mpt_pkg::OFS_MATCH_BASE + 8'h08, 32'h9);
      wr(mpt_pkg::OFS_RELEASE, 32'h4);
      repeat (25) @(posedge ref_clk);
      measure();
      chk({16'h0, hi_cnt[1]}, 32'd0);
      chk({16'h0, rise_cnt[1]}, 32'd0);
      chk({16'h0, hi_cnt[2]}, 32'd60);
      wr(mpt_pkg::OFS_CTRL, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({26'h0, pwm_out}, 32'h0);
   endtask

   task automatic test_match;
      // continue with interrupt
      wr(mpt_pkg::OFS_COUNT, 32'h0);
      wr(mpt_pkg::OFS_MATCH_BASE + 8'h04, 32'd4);
      wr(mpt_pkg::OFS_MATCH_CTRL, 32'h08);
      wr(mpt_pkg::OFS_CTRL, 32'h1);
      repeat (20) @(posedge ref_clk);
      rd(mpt_pkg::OFS_COUNT, rv);
      chk_rng(rv, 32'd5, 32'd40);
      rd_chk(mpt_pkg::OFS_IRQ_STATUS, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(mpt_pkg::OFS_IRQ_ENABLE, 32'h2);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      wr(mpt_pkg::OFS_IRQ_CLEAR, 32'h2);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      // stop with interrupt
      wr(mpt_pkg::OFS_CTRL, 32'h0);
      wr(mpt_pkg::OFS_COUNT, 32'h0);
      wr(mpt_pkg::OFS_MATCH_BASE + 8'h04, 32'd20);
      wr(mpt_pkg::OFS_MATCH_CTRL, 32'h28);
      wr(mpt_pkg::OFS_CTRL, 32'h1);
      repeat (40) @(posedge ref_clk);
      rd_chk(mpt_pkg::OFS_CTRL, 32'h0);
      rd(mpt_pkg::OFS_COUNT, rv);
      rd(mpt_pkg::OFS_COUNT, rv2);
      chk(rv2, rv);
      chk_rng(rv, 32'd20, 32'd21);
      rd_chk(mpt_pkg::OFS_IRQ_STATUS, 32'h2);
      wr(mpt_pkg::OFS_IRQ_CLEAR, 32'h2);
      rd_chk(mpt_pkg::OFS_IRQ_STATUS, 32'h0);
      // reset on match keeps count at or below the match value
      wr(mpt_pkg::OFS_MATCH_BASE + 8'h04, 32'd4);
      wr(mpt_pkg::OFS_MATCH_CTRL, 32'h10);
      wr(mpt_pkg::OFS_COUNT, 32'h0); // stop left the count past the match
      wr(mpt_pkg::OFS_CTRL, 32'h1);
      for (int i = 0; i < 6; i++)
      begin
         rd(mpt_pkg::OFS_COUNT, rv);
         chk_rng(rv, 32'd0, 32'd4);
      end
      wr(mpt_pkg::OFS_MATCH_CTRL, 32'h0);
   endtask

   task automatic test_prescale;
      wr(mpt_pkg::OFS_CTRL, 32'h0);
      wr(mpt_pkg::OFS_PRESCALE, 32'h3);
      wr(mpt_pkg::OFS_COUNT, 32'h0);
      wr(mpt_pkg::OFS_CTRL, 32'h1);
      repeat (40) @(posedge ref_clk);
      wr(mpt_pkg::OFS_CTRL, 32'h0);
      rd(mpt_pkg::OFS_COUNT, rv);
      chk_rng(rv, 32'd9, 32'd11);
      // hold-in-reset bit keeps both counts at zero
      wr(mpt_pkg::OFS_CTRL, 32'h3);
      rd_chk(mpt_pkg::OFS_COUNT, 32'h0);
      rd_chk(mpt_pkg::OFS_PS_COUNT, 32'h0);
      wr(mpt_pkg::OFS_PRESCALE, 32'h0);
   endtask

   // slow pulses so the filter sees every level
   task automatic test_count_mode;
      int sel;
      for (int m = 1; m < 4; m++)
      begin
         sel = m & 1;
         wr(mpt_pkg::OFS_CTRL, 32'h0);
         wr(mpt_pkg::OFS_COUNT, 32'h0);
         wr(mpt_pkg::OFS_CNT_MODE, 32'(m) | 32'(sel << 2));
         wr(mpt_pkg::OFS_CTRL, 32'h1);
         repeat (3)
         begin
            repeat (10) @(posedge ref_clk);
            cap_in[sel] <= 1'b1;
            repeat (10) @(posedge ref_clk);
            cap_in[sel] <= 1'b0;
         end
         repeat (12) @(posedge ref_clk);
         rd_chk(mpt_pkg::OFS_COUNT, (m == 3) ? 32'd6 : 32'd3);
      end
   endtask

   initial
   begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      test_regs();
      test_pwm();
      test_match();
      test_prescale();
      test_count_mode();
      print_verdict();
   end
endmodule // mpt_pwm_tb_top
